// ==== timer_one_pkg.sv ====
/*
 Constants and types for the sixteen-bit timer/counter: register offsets, field
 positions, reset values, mode codes and the instruction clock divide.
 Assumes a byte-addressed APB with one aligned 32-bit word per register.
*/
package timer_one_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] LOW_OFFSET = 8'h04;
	localparam logic [7:0] HIGH_OFFSET = 8'h08;
	localparam logic [7:0] IRQ_OFFSET = 8'h0C;
	localparam logic [7:0] SYSCLK_OFFSET = 8'h10;
	localparam logic [7:0] CMP_OFFSET = 8'h14;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int OVF_FLAG_BIT = 0;
	localparam int OVF_IE_BIT = 1;
	localparam int SCS_LSB = 0;
	localparam int LOW_POWER_BIT = 2;
	localparam int MODE_LSB = 4;
	localparam int IDLE_BIT = 7;

	// ----------------------------------------------------------------
	// Reset values and codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [1:0] SCS_RESET = 2'h0;
	localparam logic [1:0] SCS_SEC_OSC = 2'h1;
	localparam logic [3:0] CMP_RESET = 4'h0;
	localparam logic [3:0] CMP_SPECIAL_EVENT = 4'hB;
	localparam logic [2:0] PRESC_RESET = 3'h0;

	// Instruction cycle is four oscillator clocks
	localparam int INSTR_DIV = 4;
	localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

	typedef struct packed {
		logic wide_access_mode;
		logic sysclk_from_sec_osc;
		logic [1:0] input_prescale_sel;
		logic sec_osc_enable;
		logic ext_sync_bypass;
		logic count_source_sel;
		logic count_enable;
	} ctrl_type;

	typedef enum logic [1:0] {
		primary_run,
		secondary_run,
		secondary_idle,
		sleep_state
	} power_mode_type;

endpackage

// ==== timer_one.sv ====
/*
 Sixteen-bit timer/counter with prescaler, buffered 16-bit access, overflow
 flag, special event reset and secondary oscillator clock switching.
 Assumes an APB master on clk_i; all pin inputs are synchronous to clk_i,
 and clk_i is the oscillator clock (instruction cycle = four clocks).
*/
`timescale 1ns/1ps

// What this block does
// - Counter advances only while count_enable is set; clearing it stops counting.
// - wide_access_mode selects buffered 16-bit access, else two independent byte accesses.
// - Status bit reads 1 only while system clock comes from secondary oscillator.
// - Prescale field divides input by 1, 2, 4 or 8.
// - sec_osc_enable turns oscillator on; when clear its drive is switched off.
// - External source: bypass bit picks unsynchronised or synchronised counting.
// - Internal source counts once per instruction cycle, four clocks.
// - External source counts rising edges of pin or secondary oscillator.
// - While count_enable is set, both oscillator pins are inputs and read as zero.
// - Wide mode: low byte read copies live high byte into buffer.
// - Wide mode: high write loads buffer; low write moves buffer into counter.
// - Wide mode: live high byte is reached only through the buffer.
// - Low byte write clears prescaler; high byte write does not.
// - Enabled oscillator keeps running in every power-managed mode.
// - sys_clock_select of 01 enters secondary run mode once sec_osc_enable is set.
// - Sleep in secondary run with idle_on_sleep clear enters secondary idle.
// - Configuration bit selects low-power oscillator when set, higher power by default.
// - Counter wraps FFFF to 0000 and each wrap sets overflow_flag.
// - Interrupt request only while enabled; flag latches regardless.
// - Special event trigger resets counter in timer or synchronous modes, no flag.
// - A software counter write beats a coinciding special event reset.
module timer_one
	import timer_one_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic ext_count_pin_i,
	input wire logic sec_osc_in_pin_i,
	input wire logic [1:0] port_c_direction_i,
	input wire logic [1:0] port_c_pad_i,
	input wire logic special_event_i,
	input wire logic sleep_cmd_i,
	input wire logic wake_i,
	input wire logic sec_osc_fail_i,
	output logic [1:0] port_c_read_o,
	output logic [1:0] port_c_output_en_o,
	output logic sec_osc_drive_o,
	output logic sec_osc_low_power_o,
	output logic sysclk_sec_osc_o,
	output logic cpu_halt_o,
	output logic periph_halt_o,
	output logic overflow_irq_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	ctrl_type ctrl;
	logic [15:0] counter;
	logic [7:0] high_buf;
	logic [7:0] snap_high;
	logic [2:0] presc;
	logic [1:0] instr_cnt;
	logic overflow_flag;
	logic overflow_irq_enable;
	logic [1:0] sys_clock_select;
	logic idle_on_sleep;
	logic sec_osc_low_power_cfg;
	logic [3:0] compare_mode_code;
	power_mode_type mode;
	power_mode_type next_mode;
	logic src_q;
	logic sync1;
	logic sync2;
	logic sync3;
	logic sync_pend;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic setup;
	logic xfer;
	logic wr;
	logic rd;
	logic hit;
	logic wr_ctrl;
	logic wr_low;
	logic wr_high;
	logic wr_irq;
	logic wr_sysclk;
	logic wr_cmp;
	logic rd_low;
	logic [7:0] wbyte;

	assign setup = psel_i & ~penable_i;
	assign xfer = psel_i & penable_i & pready_o;
	// Bytes above lane 0 hold nothing, so lane 0 alone gates a write
	assign wr = xfer & pwrite_i & pstrb_i[0];
	assign rd = xfer & ~pwrite_i;
	assign wbyte = pwdata_i[7:0];
	assign hit = (paddr_i == CTRL_OFFSET) | (paddr_i == LOW_OFFSET) |
		(paddr_i == HIGH_OFFSET) | (paddr_i == IRQ_OFFSET) |
		(paddr_i == SYSCLK_OFFSET) | (paddr_i == CMP_OFFSET);
	assign wr_ctrl = wr & (paddr_i == CTRL_OFFSET);
	assign wr_low = wr & (paddr_i == LOW_OFFSET);
	assign wr_high = wr & (paddr_i == HIGH_OFFSET);
	assign wr_irq = wr & (paddr_i == IRQ_OFFSET);
	assign wr_sysclk = wr & (paddr_i == SYSCLK_OFFSET);
	assign wr_cmp = wr & (paddr_i == CMP_OFFSET);
	assign rd_low = rd & (paddr_i == LOW_OFFSET);

	// No wait state: read data is captured in setup so it leaves a flop
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= setup;
			pslverr_o <= setup & ~hit;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h0000_0000;
			snap_high <= BYTE_RESET;
		end else if (setup) begin
			snap_high <= counter[15:8];
			unique case (paddr_i)
				CTRL_OFFSET: prdata_o <= {24'h00_0000, ctrl};
				LOW_OFFSET: prdata_o <= {24'h00_0000, counter[7:0]};
				HIGH_OFFSET: prdata_o <= {24'h00_0000,
					ctrl.wide_access_mode ? high_buf : counter[15:8]};
				IRQ_OFFSET: prdata_o <= {30'h0000_0000, overflow_irq_enable, overflow_flag};
				SYSCLK_OFFSET: prdata_o <= {24'h00_0000, idle_on_sleep, 1'b0, mode,
					1'b0, sec_osc_low_power_cfg, sys_clock_select};
				CMP_OFFSET: prdata_o <= {28'h000_0000, compare_mode_code};
				default: prdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl <= CTRL_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl.wide_access_mode <= wbyte[7];
				ctrl.input_prescale_sel <= wbyte[5:4];
				ctrl.sec_osc_enable <= wbyte[3];
				ctrl.ext_sync_bypass <= wbyte[2];
				ctrl.count_source_sel <= wbyte[1];
				ctrl.count_enable <= wbyte[0];
			end
			// Read-only status follows the clock switch, never software
			ctrl.sysclk_from_sec_osc <= (next_mode == secondary_run) |
				(next_mode == secondary_idle);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sys_clock_select <= SCS_RESET;
			idle_on_sleep <= 1'b0;
			sec_osc_low_power_cfg <= 1'b0;
			compare_mode_code <= CMP_RESET;
		end else begin
			if (wr_sysclk) begin
				sys_clock_select <= wbyte[SCS_LSB +: 2];
				idle_on_sleep <= wbyte[IDLE_BIT];
				sec_osc_low_power_cfg <= wbyte[LOW_POWER_BIT];
			end
			if (wr_cmp) begin
				compare_mode_code <= wbyte[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Count source and prescaler
	// ----------------------------------------------------------------
	logic tick;
	logic src_raw;
	logic async_edge;
	logic sync_edge;
	logic sync_event;
	logic src_event;
	logic [2:0] presc_mask;
	logic inc;

	assign tick = (instr_cnt == INSTR_LAST);
	assign src_raw = ctrl.sec_osc_enable ? sec_osc_in_pin_i : ext_count_pin_i;
	assign async_edge = src_raw & ~src_q;
	assign sync_edge = sync2 & ~sync3;
	// Synchronised edges wait for the next instruction cycle boundary
	assign sync_event = tick & (sync_pend | sync_edge);

	always_comb begin
		src_event = 1'b0;
		if (ctrl.count_enable) begin
			if (!ctrl.count_source_sel) begin
				src_event = tick;
			end else begin
				src_event = ctrl.ext_sync_bypass ? async_edge : sync_event;
			end
		end
	end

	always_comb begin
		unique case (ctrl.input_prescale_sel)
			2'b00: presc_mask = 3'h0;
			2'b01: presc_mask = 3'h1;
			2'b10: presc_mask = 3'h3;
			2'b11: presc_mask = 3'h7;
		endcase
	end

	assign inc = src_event & ((presc & presc_mask) == presc_mask);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			instr_cnt <= 2'h0;
		end else begin
			instr_cnt <= instr_cnt + 2'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			src_q <= 1'b0;
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
			sync_pend <= 1'b0;
		end else begin
			src_q <= src_raw;
			sync1 <= src_raw;
			sync2 <= sync1;
			sync3 <= sync2;
			sync_pend <= (sync_pend | sync_edge) & ~tick;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			presc <= PRESC_RESET;
		end else if (wr_low) begin
			presc <= PRESC_RESET;
		end else if (src_event) begin
			presc <= presc + 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// Counter, buffer and overflow
	// ----------------------------------------------------------------
	logic special_rst;
	logic cnt_write;
	logic ovf_set;

	// Unreliable in asynchronous counting, so it is refused there
	assign special_rst = special_event_i & (compare_mode_code == CMP_SPECIAL_EVENT) &
		~(ctrl.count_source_sel & ctrl.ext_sync_bypass);
	assign cnt_write = wr_low | (wr_high & ~ctrl.wide_access_mode);
	assign ovf_set = inc & (counter == COUNT_MAX) & ~cnt_write & ~special_rst;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			counter <= COUNT_RESET;
		end else if (cnt_write) begin
			if (wr_low) begin
				counter[7:0] <= wbyte;
				if (ctrl.wide_access_mode) begin
					counter[15:8] <= high_buf;
				end
			end else begin
				counter[15:8] <= wbyte;
			end
		end else if (special_rst) begin
			counter <= COUNT_RESET;
		end else if (inc) begin
			counter <= counter + 16'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			high_buf <= BYTE_RESET;
		end else if (ctrl.wide_access_mode) begin
			if (wr_high) begin
				high_buf <= wbyte;
			end else if (rd_low) begin
				high_buf <= snap_high;
			end
		end
	end

	// Set wins over a software clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			overflow_flag <= 1'b0;
			overflow_irq_enable <= 1'b0;
		end else begin
			if (wr_irq) begin
				overflow_flag <= ovf_set | wbyte[OVF_FLAG_BIT];
				overflow_irq_enable <= wbyte[OVF_IE_BIT];
			end else begin
				overflow_flag <= overflow_flag | ovf_set;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			overflow_irq_o <= 1'b0;
		end else begin
			overflow_irq_o <= overflow_flag & overflow_irq_enable;
		end
	end

	// ----------------------------------------------------------------
	// Power modes and oscillator
	// ----------------------------------------------------------------
	always_comb begin
		next_mode = mode;
		unique case (mode)
			primary_run: begin
				if (sleep_cmd_i) begin
					next_mode = sleep_state;
				end else if (sys_clock_select == SCS_SEC_OSC && ctrl.sec_osc_enable) begin
					next_mode = secondary_run;
				end
			end
			secondary_run: begin
				if (sleep_cmd_i) begin
					next_mode = idle_on_sleep ? sleep_state : secondary_idle;
				end else if (sys_clock_select != SCS_SEC_OSC) begin
					next_mode = primary_run;
				end
			end
			secondary_idle: begin
				if (wake_i) begin
					next_mode = secondary_run;
				end
			end
			sleep_state: begin
				if (wake_i) begin
					next_mode = primary_run;
				end
			end
		endcase
		// A failed oscillator hands the clock back to the primary source
		if (sec_osc_fail_i && (next_mode == secondary_run || next_mode == secondary_idle)) begin
			next_mode = primary_run;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			mode <= primary_run;
			sysclk_sec_osc_o <= 1'b0;
			cpu_halt_o <= 1'b0;
			periph_halt_o <= 1'b0;
		end else begin
			mode <= next_mode;
			sysclk_sec_osc_o <= (next_mode == secondary_run) | (next_mode == secondary_idle);
			cpu_halt_o <= next_mode != primary_run && next_mode != secondary_run;
			periph_halt_o <= next_mode == sleep_state;
		end
	end

	// Oscillator drive ignores power mode so timekeeping survives sleep
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sec_osc_drive_o <= 1'b0;
			sec_osc_low_power_o <= 1'b0;
		end else begin
			sec_osc_drive_o <= ctrl.sec_osc_enable;
			sec_osc_low_power_o <= sec_osc_low_power_cfg;
		end
	end

	// ----------------------------------------------------------------
	// Pin override
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			port_c_read_o <= 2'h0;
			port_c_output_en_o <= 2'h0;
		end else if (ctrl.count_enable) begin
			port_c_read_o <= 2'h0;
			port_c_output_en_o <= 2'h0;
		end else begin
			port_c_read_o <= port_c_pad_i;
			port_c_output_en_o <= ~port_c_direction_i;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_stopped_count_holds: assert property (
		!ctrl.count_enable && !cnt_write && !special_rst |=> counter == $past(counter))
		else $error("counter moved while stopped");

	a_timer_one_per_cycle: assert property (
		inc && !ctrl.count_source_sel |=> !inc [*3])
		else $error("timer mode counted faster than instruction rate");

	a_low_read_pairs: assert property (
		setup && !pwrite_i && paddr_i == LOW_OFFSET && ctrl.wide_access_mode
		##1 rd_low && ctrl.wide_access_mode |=>
		high_buf == $past(counter[15:8], 2) && prdata_o[7:0] == $past(counter[7:0], 2))
		else $error("high buffer does not match low byte read");

	a_wide_low_write: assert property (
		wr_low && ctrl.wide_access_mode |=> counter == {$past(high_buf), $past(wbyte)})
		else $error("wide write did not load both bytes");

	a_wide_high_buffered: assert property (
		wr_high && ctrl.wide_access_mode && !special_rst && !inc
		|=> counter == $past(counter) && high_buf == $past(wbyte))
		else $error("wide high write reached the live counter");

	a_presc_low_clear: assert property (
		wr_low |=> presc == PRESC_RESET)
		else $error("low write left prescaler count");

	a_presc_high_keep: assert property (
		wr_high && !src_event |=> presc == $past(presc))
		else $error("high write disturbed prescaler");

	a_wrap_sets_flag: assert property (
		inc && counter == COUNT_MAX && !cnt_write && !special_rst
		|=> counter == COUNT_RESET && overflow_flag)
		else $error("wrap did not set overflow flag");

	a_special_no_flag: assert property (
		special_rst && !cnt_write && !overflow_flag && !wr_irq
		|=> counter == COUNT_RESET && !overflow_flag)
		else $error("special event reset misbehaved");

	a_write_beats_event: assert property (
		wr_low && special_rst |=> counter[7:0] == $past(wbyte))
		else $error("special event overrode a write");

	a_irq_needs_enable: assert property (
		overflow_irq_o |-> $past(overflow_irq_enable) && $past(overflow_flag))
		else $error("interrupt without enable and flag");

	a_status_tracks_mode: assert property (
		ctrl.sysclk_from_sec_osc == (mode == secondary_run || mode == secondary_idle))
		else $error("clock status bit disagrees with mode");

	a_pins_read_zero: assert property (
		ctrl.count_enable |=> port_c_read_o == 2'h0 && port_c_output_en_o == 2'h0)
		else $error("pins not forced to input while enabled");

	a_osc_follows_enable: assert property (
		##1 sec_osc_drive_o == $past(ctrl.sec_osc_enable))
		else $error("oscillator drive not following enable");

	c_overflow: cover property (ovf_set);
	c_wide_read: cover property (rd_low && ctrl.wide_access_mode);
	c_special_reset: cover property (special_rst && counter != COUNT_RESET);
	c_secondary_idle: cover property (mode == secondary_run ##1 mode == secondary_idle);

endmodule // timer_one

// ==== sec_clock_source.sv ====
/*
 Far-side model: a source on the external count pin and the secondary
 crystal. Assumes the bench clock; edges land on whole clock cycles.
*/
`timescale 1ns/1ps
module sec_clock_source #(
	parameter int START_CYCLES = 40,
	parameter int HALF = 4
) (
	input wire logic clk_i,
	input wire logic burst_i,
	input wire logic [7:0] pulses_i,
	input wire logic osc_drive_i,
	output logic ext_pin_o,
	output logic osc_pin_o
);
	int left = 0;
	int phase = 0;
	int warm = 0;
	initial begin
		ext_pin_o = 1'b0;
		osc_pin_o = 1'b0;
	end
	// ----------------------------------------------------------------
	// Count pin: bursts of rising edges, idle low between bursts
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (burst_i) begin
			left <= 2 * pulses_i;
			phase <= 0;
		end else if (left > 0) begin
			phase <= (phase == HALF - 1) ? 0 : phase + 1;
			if (phase == HALF - 1) begin
				ext_pin_o <= ~ext_pin_o;
				left <= left - 1;
			end
		end
	end
	// ----------------------------------------------------------------
	// Crystal: dead until driven, then silent for start-up
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		warm <= osc_drive_i ? ((warm < START_CYCLES) ? warm + 1 : warm) : 0;
		if (!osc_drive_i) begin
			osc_pin_o <= 1'b0;
		end else if (warm == START_CYCLES) begin
			osc_pin_o <= ~osc_pin_o;
		end
	end
endmodule // sec_clock_source

// ==== timer_one_bench.sv ====
/*
 Self-checking bench for the timer/counter: APB register access, counting,
 buffered access, overflow, special event and clock switching.
 Assumes the package constants; the APB master waits for pready however long it takes.
*/
`timescale 1ns/1ps
module timer_one_bench
	import timer_one_pkg::*;
;
	typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] r;} row_type;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, perr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0] pstrb;
	logic [1:0] dir, pad, pc_read, pc_oe;
	logic sev, sleep, wake, fail, burst, ext_pin, osc_pin;
	logic osc_drive, lowp, sysclk, cpu_halt, periph_halt, irq;
	logic [7:0] pulses;
	int mismatches = 0;
	int cmp_count = 0;
	int exp;
	row_type rows [9];

	timer_one DUT (.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.ext_count_pin_i(ext_pin), .sec_osc_in_pin_i(osc_pin),
		.port_c_direction_i(dir), .port_c_pad_i(pad), .special_event_i(sev),
		.sleep_cmd_i(sleep), .wake_i(wake), .sec_osc_fail_i(fail),
		.port_c_read_o(pc_read), .port_c_output_en_o(pc_oe),
		.sec_osc_drive_o(osc_drive), .sec_osc_low_power_o(lowp),
		.sysclk_sec_osc_o(sysclk), .cpu_halt_o(cpu_halt),
		.periph_halt_o(periph_halt), .overflow_irq_o(irq));
	sec_clock_source far (.clk_i(clk), .burst_i(burst), .pulses_i(pulses),
		.osc_drive_i(osc_drive), .ext_pin_o(ext_pin), .osc_pin_o(osc_pin));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			mismatches++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= 32'(d);
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 8'h00);
	endtask
	// One-cycle strobes, packed as {burst, sev, sleep, wake}
	task automatic pulse(input logic [3:0] m);
		@(posedge clk);
		{burst, sev, sleep, wake} <= m;
		@(posedge clk);
		{burst, sev, sleep, wake} <= 4'h0;
		repeat (3) @(posedge clk);
	endtask
	task automatic end_of_test();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#(20000 * 5);
		mismatches++;
		end_of_test();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata, sev, sleep, wake, fail, burst} = '0;
		pstrb = 4'hF;
		dir = 2'b01;
		pad = 2'b11;
		pulses = 8'h00;
		rst_n = 1'b0;
		rows = '{'{CTRL_OFFSET, 8'hFE, 8'hBE}, '{CTRL_OFFSET, 8'h00, 8'h00},
			'{IRQ_OFFSET, 8'hFE, 8'h02}, '{IRQ_OFFSET, 8'h00, 8'h00},
			'{SYSCLK_OFFSET, 8'hB4, 8'h84}, '{SYSCLK_OFFSET, 8'h00, 8'h00},
			'{CMP_OFFSET, 8'hFB, 8'h0B}, '{LOW_OFFSET, 8'h5A, 8'h5A},
			'{HIGH_OFFSET, 8'hA5, 8'hA5}};
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(8'(i * 4));
			check(q, 0);
		end
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a);
			check(q, 32'(rows[i].r));
		end
		rd(8'h18);
		check(q, 0);
		check(perr, 1);
		pstrb <= 4'h0;
		wr(CTRL_OFFSET, 8'h01);
		pstrb <= 4'hF;
		rd(CTRL_OFFSET);
		check(q, 0);
		// Timer mode per prescale; the free tick phase costs one count
		for (int ps = 0; ps < 4; ps++) begin
			wr(LOW_OFFSET, 8'h00);
			wr(CTRL_OFFSET, 8'(1 + ps * 16));
			repeat (256) @(posedge clk);
			wr(CTRL_OFFSET, 8'h00);
			rd(LOW_OFFSET);
			exp = 259 / (4 << ps);
			check(int'(q) >= exp - 1 && int'(q) <= exp + 1, 1);
			exp = int'(q);
			repeat (20) @(posedge clk);
			rd(LOW_OFFSET);
			check(q, 32'(exp));
		end
		// External pin, synchronised then not
		for (int sb = 0; sb < 2; sb++) begin
			wr(LOW_OFFSET, 8'h00);
			wr(CTRL_OFFSET, 8'(3 + sb * 4));
			pulses <= 8'd9;
			pulse(4'h8);
			repeat (100) @(posedge clk);
			check({pc_read, pc_oe}, 0);
			rd(LOW_OFFSET);
			check(q, 9);
		end
		wr(CTRL_OFFSET, 8'h00);
		repeat (2) @(posedge clk);
		check(pc_oe, 2'b10);
		// Buffered wide access
		wr(CTRL_OFFSET, 8'h80);
		wr(HIGH_OFFSET, 8'h12);
		wr(LOW_OFFSET, 8'h34);
		wr(CTRL_OFFSET, 8'h00);
		rd(HIGH_OFFSET);
		check(q, 8'h12);
		wr(CTRL_OFFSET, 8'h80);
		wr(HIGH_OFFSET, 8'h77);
		wr(CTRL_OFFSET, 8'h00);
		rd(HIGH_OFFSET);
		check(q, 8'h12);
		wr(CTRL_OFFSET, 8'h80);
		rd(LOW_OFFSET);
		check(q, 8'h34);
		rd(HIGH_OFFSET);
		check(q, 8'h12);
		// Overflow, masked then unmasked
		wr(CTRL_OFFSET, 8'h00);
		wr(HIGH_OFFSET, 8'hFF);
		wr(LOW_OFFSET, 8'hFE);
		wr(CTRL_OFFSET, 8'h01);
		repeat (40) @(posedge clk);
		wr(CTRL_OFFSET, 8'h00);
		rd(HIGH_OFFSET);
		check(q, 0);
		rd(IRQ_OFFSET);
		check(q, 1);
		check(irq, 0);
		wr(IRQ_OFFSET, 8'h02);
		wr(HIGH_OFFSET, 8'hFF);
		wr(LOW_OFFSET, 8'hFF);
		wr(CTRL_OFFSET, 8'h01);
		repeat (20) @(posedge clk);
		check(irq, 1);
		// Special event reset sets no flag
		wr(IRQ_OFFSET, 8'h00);
		wr(CMP_OFFSET, 8'h0B);
		wr(HIGH_OFFSET, 8'h40);
		pulse(4'h4);
		wr(CTRL_OFFSET, 8'h00);
		rd(HIGH_OFFSET);
		check(q, 0);
		rd(IRQ_OFFSET);
		check(q, 0);
		// Clock switching and power modes
		wr(CTRL_OFFSET, 8'h08);
		repeat (2) @(posedge clk);
		check(osc_drive, 1);
		wr(SYSCLK_OFFSET, 8'h05);
		repeat (2) @(posedge clk);
		check({sysclk, lowp}, 2'b11);
		rd(CTRL_OFFSET);
		check(q, 8'h48);
		rd(SYSCLK_OFFSET);
		check(q, 8'h15);
		pulse(4'h2);
		check({cpu_halt, periph_halt, osc_drive}, 3'b101);
		pulse(4'h1);
		check(cpu_halt, 0);
		fail <= 1'b1;
		repeat (3) @(posedge clk);
		check(sysclk, 0);
		rd(CTRL_OFFSET);
		check(q, 8'h08);
		// Crystal start-up allowance before counting its edges
		repeat (50) @(posedge clk);
		wr(LOW_OFFSET, 8'h00);
		wr(CTRL_OFFSET, 8'h0F);
		repeat (20) @(posedge clk);
		wr(CTRL_OFFSET, 8'h08);
		rd(LOW_OFFSET);
		check(q >= 11 && q <= 12, 1);
		fail <= 1'b0;
		// Second reset in mid-run
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check({sysclk, osc_drive, irq}, 0);
		end_of_test();
	end
endmodule // timer_one_bench
